//--- rtl/dcte_pkg.sv
// package for the channel termination and error block
package dcte_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_ERROR = 8'h04;
  localparam logic [7:0] ADDR_CONTROL = 8'h08;
  localparam logic [7:0] ADDR_CONFIG = 8'h0C;
  localparam logic [7:0] ADDR_MEM_COUNT = 8'h10;
  localparam logic [7:0] ADDR_BASE_COUNT = 8'h14;
  localparam logic [7:0] ADDR_MEM_ADDR = 8'h18;
  localparam logic [7:0] ADDR_DEV_ADDR = 8'h1C;
  localparam logic [7:0] ADDR_BASE_ADDR = 8'h20;
  localparam logic [7:0] ADDR_CHANNEL_CFG = 8'h24;
  // status register bit positions
  localparam int ST_ACT = 0;
  localparam int ST_COC = 1;
  localparam int ST_BTC = 2;
  localparam int ST_NDT = 3;
  localparam int ST_ERR = 4;
  localparam int ST_PCT = 5;
  // control register bit positions
  localparam int CT_STR = 0;
  localparam int CT_CNT = 1;
  localparam int CT_SAB = 2;
  // error register: interrupt enable above the code field
  localparam int ER_IRQ_EN = 5;
  // config register fields
  localparam int CF_EXTREQ = 0;
  localparam int CF_DUAL = 1;
  localparam int CF_CHAIN_LO = 2;
  localparam int CF_PCL_ABORT = 4;
  localparam int CF_DEV8 = 5;
  localparam int CF_SIZE_LO = 6;
  localparam int CF_RSVD = 8;
  localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
  // chaining modes
  localparam logic [1:0] CHAIN_NONE = 2'h0;
  localparam logic [1:0] CHAIN_RSVD = 2'h1;
  localparam logic [1:0] CHAIN_SEQ = 2'h2;
  localparam logic [1:0] CHAIN_LINK = 2'h3;
  // operand sizes
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_WORD = 2'h1;
  localparam logic [1:0] SIZE_LONG = 2'h2;
  localparam logic [1:0] SIZE_RSVD = 2'h3;
  // error codes
  localparam logic [4:0] EC_NONE = 5'h00;
  localparam logic [4:0] EC_CONFIG = 5'h01;
  localparam logic [4:0] EC_TIMING = 5'h02;
  localparam logic [4:0] EC_ADDRESS = 5'h05;
  localparam logic [4:0] EC_BUS = 5'h09;
  localparam logic [4:0] EC_COUNT = 5'h0D;
  localparam logic [4:0] EC_EXT_ABORT = 5'h10;
  localparam logic [4:0] EC_SW_ABORT = 5'h11;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // bus exception code for bus error
  localparam logic [2:0] BEC_BUS_ERROR = 3'h2;
endpackage

//--- rtl/dcte_top.sv
// channel termination and error detection for one dma channel
// Function
// - final outcome of every ended channel recorded in status register
// - done driven from start to end of the final operand when count is one, external request
// - count reaching zero ends channel: active clear, completion set
// - peripheral done with transfer-complete during device access ends channel
// - incoming done accepted only when sampled high on two edges
// - dual address: done in any cycle; 8-bit device finishes whole operand
// - device termination sets completion and device-termination flags
// - done while we drive done ends channel without device-termination flag
// - error sets completion and error flags and writes error code
// - bad configuration at start gives configuration error, no start
// - start with any status flag except PCT set gives operation timing error
// - continue misuse gives operation timing error
// - writes to channel registers other than status, error, control, base count and base address while started or active give timing error
// - chip select or acknowledge while bus master gives address error
// - word access to odd address gives address error before transfer
// - bus error exception code ends channel with bus error
// - zero memory count at start without chaining gives count error
// - block end with continue and zero base count gives count error
// - sequential chaining with zero base count gives count error at start
// - continue or chain loading zero memory count gives count error
// - abort input transition or software abort gives abort error
// - count zero with continue reloads, clears continue, sets block complete
//
// The AXI4-Lite interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
module dcte_top
  import dcte_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // operand engine events, same clock
  input wire logic op_begin,
  input wire logic op_done,
  input wire logic op_last_dev_cycle,
  input wire logic op_first_cycle,
  input wire logic dev_access,
  input wire logic odd_word_access,
  input wire logic block_load,
  input wire logic [31:0] load_count,
  // pins from outside
  input wire logic done_in,
  input wire logic transfer_complete_signal,
  input wire logic peripheral_control_line,
  input wire logic chip_select,
  input wire logic interrupt_acknowledge,
  input wire logic [2:0] bus_exception,
  input wire logic ready_in,
  input wire logic bus_master,
  output logic done_out,
  output logic channel_active,
  output logic reload_base,
  output logic channel_ready,
  output logic abort_cycle,
  output logic irq_request
);
  typedef struct packed {
    logic [5:0] status;
    logic [4:0] ecode;
    logic cont;
    logic start;
    logic [31:0] cfg;
    logic irq_en;
    logic [31:0] mcount;
    logic [31:0] bcount;
    logic [31:0] maddr;
    logic [31:0] daddr;
    logic [31:0] baddr;
    logic [1:0] done_sync;
    logic done_seen;
    logic [1:0] pcl_sync;
    logic pcl_prev;
    logic [1:0] cs_sync;
    logic [1:0] ia_sync;
    logic [1:0] rdy_sync;
    logic [1:0] dtc_sync;
    logic [2:0] bec_s1;
    logic [2:0] bec_s2;
    logic pend_dev_term;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic done_drv;
    logic reload;
    logic ready_o;
    logic abort_o;
    logic irq;
  } dcte_state_t;
  dcte_state_t s_q, s_d;
  function automatic logic known_addr(input logic [7:0] a);
    known_addr = (a[1:0] == 2'h0) && (a <= ADDR_CHANNEL_CFG);
  endfunction
  function automatic logic cfg_bad(input logic [31:0] c);
    cfg_bad = (c[CF_CHAIN_LO +: 2] == CHAIN_RSVD) || (c[CF_SIZE_LO +: 2] == SIZE_RSVD)
      || (c[31:CF_RSVD] != 24'h000000)
      // single address cannot split a wide operand for a byte-wide device
      || (c[CF_DEV8] && !c[CF_DUAL] && c[CF_SIZE_LO +: 2] != SIZE_BYTE);
  endfunction
  always_comb
  begin
    logic err;
    logic [4:0] code;
    logic normal_end;
    logic dev_end;
    logic wr_fire;
    logic done_valid;
    logic pcl_fall;
    logic act;
    err = 1'b0;
    code = EC_NONE;
    normal_end = 1'b0;
    dev_end = 1'b0;
    s_d = s_q;
    act = s_q.status[ST_ACT];
    s_d.done_sync = {s_q.done_sync[0], done_in};
    s_d.pcl_sync = {s_q.pcl_sync[0], peripheral_control_line};
    s_d.cs_sync = {s_q.cs_sync[0], chip_select};
    s_d.ia_sync = {s_q.ia_sync[0], interrupt_acknowledge};
    s_d.rdy_sync = {s_q.rdy_sync[0], ready_in};
    s_d.dtc_sync = {s_q.dtc_sync[0], transfer_complete_signal};
    s_d.bec_s1 = bus_exception;
    s_d.bec_s2 = s_q.bec_s1;
    s_d.pcl_prev = s_q.pcl_sync[1];
    // two successive high samples of the synchronised done
    s_d.done_seen = s_q.done_sync[1];
    done_valid = s_q.done_sync[1] && s_q.done_seen;
    pcl_fall = s_q.pcl_prev && !s_q.pcl_sync[1];
    if (pcl_fall)
    begin
      s_d.status[ST_PCT] = 1'b1;
    end
    s_d.ready_o = act && s_q.rdy_sync[1];
    s_d.reload = 1'b0;
    s_d.abort_o = 1'b0;
    // done out from the start of the final operand until its op_done
    if (act && s_q.cfg[CF_EXTREQ] && op_begin && s_q.mcount == 32'h1)
    begin
      s_d.done_drv = 1'b1;
    end
    // device done: any cycle in dual mode, else only with transfer-complete
    if (act && s_q.cfg[CF_EXTREQ] && done_valid && dev_access
      && (s_q.cfg[CF_DUAL] || s_q.dtc_sync[1]))
    begin
      s_d.pend_dev_term = 1'b1;
    end
    if (act && op_done)
    begin
      s_d.mcount = s_q.mcount - 32'h1;
      s_d.maddr = s_q.maddr + 32'h1;
      s_d.daddr = s_q.daddr + 32'h1;
      s_d.done_drv = 1'b0;
      s_d.pend_dev_term = 1'b0;
      if (s_q.mcount == 32'h1)
      begin
        if (s_q.cont)
        begin
          if (s_q.bcount == 32'h0)
          begin
            err = 1'b1;
            code = EC_COUNT;
          end
          else
          begin
            s_d.mcount = s_q.bcount;
            s_d.maddr = s_q.baddr;
            s_d.cont = 1'b0;
            s_d.status[ST_BTC] = 1'b1;
            s_d.reload = 1'b1;
          end
        end
        else
        begin
          normal_end = 1'b1;
        end
      end
      else if (s_q.pend_dev_term)
      begin
        // our own done already out means it is an ordinary end
        dev_end = !s_q.done_drv;
        normal_end = s_q.done_drv;
      end
    end
    if (act && block_load && load_count == 32'h0)
    begin
      err = 1'b1;
      code = EC_COUNT;
    end
    else if (act && block_load)
    begin
      s_d.mcount = load_count;
    end
    if (act && bus_master && (s_q.cs_sync[1] || s_q.ia_sync[1]))
    begin
      err = 1'b1;
      code = EC_ADDRESS;
    end
    if (act && odd_word_access)
    begin
      err = 1'b1;
      code = EC_ADDRESS;
    end
    if (act && s_q.bec_s2 == BEC_BUS_ERROR)
    begin
      err = 1'b1;
      code = EC_BUS;
    end
    if (act && s_q.cfg[CF_PCL_ABORT] && s_q.status[ST_PCT])
    begin
      err = 1'b1;
      code = EC_EXT_ABORT;
    end
    // register writes
    wr_fire = s_q.aw_got && s_q.w_got && !s_q.bvalid;
    if (s_axi_awvalid && !s_q.aw_got)
    begin
      s_d.aw_got = 1'b1;
      s_d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_q.w_got)
    begin
      s_d.w_got = 1'b1;
      s_d.wdata = s_axi_wdata;
    end
    if (wr_fire)
    begin
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = known_addr(s_q.awaddr) ? RESP_OKAY : RESP_SLVERR;
      case (s_q.awaddr)
        ADDR_STATUS:
        begin
          // write one to clear; error code goes with the error flag
          // bits set by hardware in this same cycle survive the clear
          s_d.status[5:1] = (s_q.status[5:1] & ~s_q.wdata[5:1]) | (s_d.status[5:1] & ~s_q.status[5:1]);
          if (s_q.wdata[ST_ERR])
          begin
            s_d.ecode = EC_NONE;
          end
        end
        ADDR_CONTROL:
        begin
          if (s_q.wdata[CT_SAB] && (act || s_q.start))
          begin
            err = 1'b1;
            code = EC_SW_ABORT;
          end
          else if (s_q.wdata[CT_CNT] && (!s_q.wdata[CT_STR] && !act || act && s_q.status[ST_BTC]))
          begin
            err = 1'b1;
            code = EC_TIMING;
          end
          else if (s_q.wdata[CT_STR])
          begin
            if (act || s_q.status[4:1] != 4'h0)
            begin
              err = 1'b1;
              code = EC_TIMING;
            end
            else if (cfg_bad(s_q.cfg))
            begin
              err = 1'b1;
              code = EC_CONFIG;
            end
            else if (s_q.cfg[CF_CHAIN_LO +: 2] == CHAIN_NONE && s_q.mcount == 32'h0)
            begin
              err = 1'b1;
              code = EC_COUNT;
            end
            else if (s_q.cfg[CF_CHAIN_LO +: 2] == CHAIN_SEQ && s_q.bcount == 32'h0)
            begin
              err = 1'b1;
              code = EC_COUNT;
            end
            else if (s_q.cfg[CF_CHAIN_LO +: 2] != CHAIN_NONE && s_q.baddr[0])
            begin
              err = 1'b1;
              code = EC_ADDRESS;
            end
            else
            begin
              s_d.status[ST_ACT] = 1'b1;
              s_d.cont = s_q.wdata[CT_CNT];
            end
          end
          else if (s_q.wdata[CT_CNT])
          begin
            s_d.cont = 1'b1;
          end
        end
        ADDR_ERROR:
        begin
          s_d.irq_en = s_q.wdata[ER_IRQ_EN];
        end
        default:
        begin
          // base registers stay writable: continue mode reloads them mid-run
          if (known_addr(s_q.awaddr) && s_q.awaddr != ADDR_BASE_COUNT && s_q.awaddr != ADDR_BASE_ADDR
            && (act || s_q.start))
          begin
            err = 1'b1;
            code = EC_TIMING;
          end
          else if (!(act && bus_master && (s_q.cs_sync[1] || s_q.ia_sync[1])))
          begin
            case (s_q.awaddr)
              ADDR_CONFIG: s_d.cfg = s_q.wdata;
              ADDR_MEM_COUNT: s_d.mcount = s_q.wdata;
              ADDR_BASE_COUNT: s_d.bcount = s_q.wdata;
              ADDR_MEM_ADDR: s_d.maddr = s_q.wdata;
              ADDR_DEV_ADDR: s_d.daddr = s_q.wdata;
              ADDR_BASE_ADDR: s_d.baddr = s_q.wdata;
              default: s_d.cfg = s_d.cfg;
            endcase
          end
        end
      endcase
    end
    if (s_q.bvalid && s_axi_bready)
    begin
      s_d.bvalid = 1'b0;
    end
    // end of channel: hardware sets win over same-cycle clears
    if (err)
    begin
      s_d.status[ST_ACT] = 1'b0;
      s_d.status[ST_COC] = 1'b1;
      s_d.status[ST_ERR] = 1'b1;
      s_d.ecode = code;
      s_d.abort_o = act;
      s_d.done_drv = 1'b0;
      s_d.pend_dev_term = 1'b0;
    end
    else if (normal_end || dev_end)
    begin
      s_d.status[ST_ACT] = 1'b0;
      s_d.status[ST_COC] = 1'b1;
      if (dev_end)
      begin
        s_d.status[ST_NDT] = 1'b1;
      end
    end
    s_d.irq = s_q.irq_en && (s_d.status[ST_COC] || s_d.status[ST_BTC]);
    // reads
    if (s_axi_arvalid && !s_q.rvalid)
    begin
      s_d.rvalid = 1'b1;
      s_d.rresp = known_addr(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      case (s_axi_araddr)
        ADDR_STATUS: s_d.rdata = {26'h0, s_q.status};
        ADDR_ERROR: s_d.rdata = {26'h0, s_q.irq_en, s_q.ecode};
        ADDR_CONTROL: s_d.rdata = {29'h0, 1'b0, s_q.cont, s_q.start};
        ADDR_CONFIG: s_d.rdata = s_q.cfg;
        ADDR_MEM_COUNT: s_d.rdata = s_q.mcount;
        ADDR_BASE_COUNT: s_d.rdata = s_q.bcount;
        ADDR_MEM_ADDR: s_d.rdata = s_q.maddr;
        ADDR_DEV_ADDR: s_d.rdata = s_q.daddr;
        ADDR_BASE_ADDR: s_d.rdata = s_q.baddr;
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end
    else if (s_q.rvalid && s_axi_rready)
    begin
      s_d.rvalid = 1'b0;
    end
    s_d.start = s_d.status[ST_ACT];
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end
  assign s_axi_awready = !s_q.aw_got;
  assign s_axi_wready = !s_q.w_got;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = !s_q.rvalid;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign done_out = s_q.done_drv;
  assign channel_active = s_q.status[ST_ACT];
  assign reload_base = s_q.reload;
  assign channel_ready = s_q.ready_o;
  assign abort_cycle = s_q.abort_o;
  assign irq_request = s_q.irq;
endmodule // dcte_top

//--- bench/dcte_props.sv
// assertion checker for the channel termination block
`timescale 1ns/1ps
module dcte_props
  import dcte_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic op_begin,
  input wire logic op_done,
  input wire logic odd_word_access,
  input wire logic chip_select,
  input wire logic interrupt_acknowledge,
  input wire logic [2:0] bus_exception,
  input wire logic bus_master,
  input wire logic done_out,
  input wire logic channel_active,
  input wire logic reload_base,
  input wire logic channel_ready,
  input wire logic abort_cycle
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  AST_DONE_RISE:
    assert property ($rose(done_out) |-> $past(op_begin) && channel_active)
    else $error("done rose without operand start");
  AST_DONE_END:
    assert property (done_out && op_done |=> !channel_active || reload_base)
    else $error("channel still active after last operand");
  AST_ABORT_ENDS:
    assert property (abort_cycle |-> !channel_active)
    else $error("abort pulse on active channel");
  AST_READY_GATED:
    assert property (!channel_active && !$past(channel_active) |-> !channel_ready)
    else $error("ready passed while inactive");
  AST_BUS_ERR:
    assert property (channel_active && bus_exception == BEC_BUS_ERROR |-> ##[1:5] !channel_active)
    else $error("bus error did not end channel");
  // two sync stages plus the status register
  AST_CS_ABORT:
    assert property (channel_active && bus_master && (chip_select || interrupt_acknowledge)
      |-> ##[1:5] !channel_active)
    else $error("select while master did not end channel");
  AST_ODD_ADDR:
    assert property (channel_active && odd_word_access |-> ##[1:3] !channel_active)
    else $error("odd access did not end channel");
  AST_RVALID_LAT:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
endmodule // dcte_props

bind dcte_top dcte_props i_props (.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .op_begin, .op_done, .odd_word_access, .chip_select, .interrupt_acknowledge, .bus_exception,
  .bus_master, .done_out, .channel_active, .reload_base, .channel_ready, .abort_cycle);

//--- bench/dcte_periph.sv
// peripheral model: done, transfer complete and control line
`timescale 1ns/1ps
module dcte_periph
(
  input wire logic aclk,
  input wire logic term,
  input wire logic [3:0] len,
  input wire logic abort,
  output logic done_in,
  output logic transfer_complete_signal,
  output logic peripheral_control_line
);
  logic [3:0] dn_q = 4'h0;
  logic [3:0] an_q = 4'h0;
  logic term_q = 1'h0;
  logic abort_q = 1'h0;
  always_ff @(posedge aclk)
  begin
    term_q <= term;
    abort_q <= abort;
    if (term && !term_q)
      dn_q <= len;
    else if (dn_q != 4'h0)
      dn_q <= dn_q - 4'h1;
    if (abort && !abort_q)
      an_q <= 4'h8;
    else if (an_q != 4'h0)
      an_q <= an_q - 4'h1;
  end
  // released lines fall back low, the idle level
  assign done_in = dn_q != 4'h0;
  assign transfer_complete_signal = dn_q != 4'h0;
  // high then low: only the falling edge arms the abort
  assign peripheral_control_line = an_q > 4'h4;
endmodule // dcte_periph

//--- bench/tb_dma_channel_termination_errors.sv
// self-checking bench for the channel termination block
`timescale 1ns/1ps
module tb_dma_channel_termination_errors;
  import dcte_pkg::*;
  logic aclk = 1'h0, aresetn = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, load_count = 32'h0, rdat;
  logic [3:0] s_axi_wstrb = 4'hF, len = 4'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
  logic s_axi_rready = 1'h0, op_begin = 1'h0, op_done = 1'h0, op_last_dev_cycle = 1'h0;
  logic op_first_cycle = 1'h0, dev_access = 1'h0, odd_word_access = 1'h0, block_load = 1'h0;
  logic chip_select = 1'h0, interrupt_acknowledge = 1'h0, ready_in = 1'h0, bus_master = 1'h0;
  logic [2:0] bus_exception = 3'h0;
  logic term = 1'h0, abort = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rresp_q;
  logic [31:0] s_axi_rdata;
  logic done_in, transfer_complete_signal, peripheral_control_line;
  logic done_out, channel_active, reload_base, channel_ready, abort_cycle, irq_request;
  logic [31:0] scfg [7] = '{32'h100, 32'h0, 32'h0, 32'h4, 32'hC0, 32'h8, 32'h60};
  logic [31:0] scnt [7] = '{32'h5, 32'h0, 32'h5, 32'h5, 32'h5, 32'h5, 32'h5};
  logic [31:0] sctl [7] = '{32'h1, 32'h1, 32'h2, 32'h1, 32'h1, 32'h1, 32'h1};
  logic [4:0] scode [7] = '{EC_CONFIG, EC_COUNT, EC_TIMING, EC_CONFIG, EC_CONFIG, EC_COUNT, EC_CONFIG};
  logic [4:0] acode [7] = '{EC_SW_ABORT, EC_TIMING, EC_BUS, EC_ADDRESS, EC_EXT_ABORT, EC_ADDRESS, EC_ADDRESS};
  int n_mismatch = 0;
  int checks = 0;

  always #5 aclk = ~aclk;

  dcte_top i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .op_begin, .op_done, .op_last_dev_cycle, .op_first_cycle, .dev_access,
    .odd_word_access, .block_load, .load_count, .done_in, .transfer_complete_signal,
    .peripheral_control_line, .chip_select, .interrupt_acknowledge, .bus_exception, .ready_in,
    .bus_master, .done_out, .channel_active, .reload_base, .channel_ready, .abort_cycle, .irq_request);
  dcte_periph i_periph (.aclk, .term, .len, .abort, .done_in, .transfer_complete_signal,
    .peripheral_control_line);

  task automatic summarize;
  begin
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  end
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
  begin
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  end
  endtask

  // each access opens one edge after the previous one closed
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
  begin
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'h0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid)
        break;
    end
    s_axi_bready <= 1'h0;
    if (n == 50)
    begin
      n_mismatch++;
      summarize;
    end
  end
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    int n;
  begin
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid)
        break;
    end
    rdat = s_axi_rdata;
    rresp_q = s_axi_rresp;
    s_axi_rready <= 1'h0;
    chk(rdat, e);
    if (n == 50)
    begin
      n_mismatch++;
      summarize;
    end
  end
  endtask

  task automatic go(input logic [31:0] cfg, input logic [31:0] cnt, input logic [31:0] ctl);
  begin
    wr(ADDR_CONFIG, cfg);
    wr(ADDR_BASE_COUNT, 32'h0);
    wr(ADDR_MEM_COUNT, cnt);
    wr(ADDR_CONTROL, ctl);
  end
  endtask

  task automatic fault(input logic [4:0] code, input logic [31:0] st);
  begin
    rc(ADDR_STATUS, st);
    rc(ADDR_ERROR, {27'h0, code});
    wr(ADDR_STATUS, 32'h3E);
    rc(ADDR_ERROR, 32'h0);
    rc(ADDR_STATUS, 32'h0);
  end
  endtask

  initial
  begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    ready_in <= 1'h1;
    rc(ADDR_STATUS, 32'h0);
    rc(ADDR_CONFIG, CONFIG_RESET);
    rc(8'h28, 32'h0);
    chk({30'h0, rresp_q}, {30'h0, RESP_SLVERR});
    $display("reset and map done");
    for (int i = 0; i < 7; i++)
    begin
      go(scfg[i], scnt[i], sctl[i]);
      fault(scode[i], 32'h12);
    end
    $display("start errors done");
    go(32'h1, 32'h1, 32'h1);
    op_begin <= 1'h1;
    @(posedge aclk);
    op_begin <= 1'h0;
    op_done <= 1'h1;
    @(posedge aclk);
    op_done <= 1'h0;
    chk(done_out, 1'h1);
    @(posedge aclk);
    chk(channel_active, 1'h0);
    rc(ADDR_STATUS, 32'h02);
    wr(ADDR_CONTROL, 32'h1);
    fault(EC_TIMING, 32'h12);
    $display("count end done");
    go(32'h1, 32'h4, 32'h1);
    // a one-cycle done must be ignored, a six-cycle one must end the channel
    for (int j = 1; j < 7; j += 5)
    begin
      len <= j[3:0];
      term <= 1'h1;
      dev_access <= 1'h1;
      @(posedge aclk);
      term <= 1'h0;
      repeat (6) @(posedge aclk);
      dev_access <= 1'h0;
      op_done <= 1'h1;
      @(posedge aclk);
      op_done <= 1'h0;
      @(posedge aclk);
      chk(channel_active, j == 1);
    end
    rc(ADDR_STATUS, 32'h0A);
    wr(ADDR_STATUS, 32'h3E);
    $display("device end done");
    for (int i = 0; i < 7; i++)
    begin
      go(i == 4 ? 32'h11 : 32'h1, 32'h4, 32'h1);
      repeat (3) @(posedge aclk);
      chk(channel_active, 1'h1);
      chk(channel_ready, 1'h1);
      case (i)
        0: wr(ADDR_CONTROL, 32'h4);
        1: wr(ADDR_MEM_ADDR, 32'h100);
        2: bus_exception <= BEC_BUS_ERROR;
        3: chip_select <= 1'h1;
        4: abort <= 1'h1;
        5: odd_word_access <= 1'h1;
        default: interrupt_acknowledge <= 1'h1;
      endcase
      bus_master <= i == 3 || i == 6;
      repeat (8) @(posedge aclk);
      {bus_exception, chip_select, abort, odd_word_access, interrupt_acknowledge, bus_master} <= '0;
      fault(acode[i], i == 4 ? 32'h32 : 32'h12);
    end
    $display("active errors done");
    // block end with zero base count, then a chain step loading zero
    for (int k = 0; k < 2; k++)
    begin
      go(32'h1, k ? 32'h4 : 32'h1, k ? 32'h1 : 32'h3);
      op_done <= k == 0;
      block_load <= k == 1;
      @(posedge aclk);
      {op_done, block_load} <= '0;
      @(posedge aclk);
      chk(abort_cycle, 1'h1);
      fault(EC_COUNT, 32'h12);
    end
    $display("count errors done");
    wr(ADDR_ERROR, 32'h20);
    rc(ADDR_ERROR, 32'h20);
    go(32'h1, 32'h1, 32'h3);
    wr(ADDR_BASE_COUNT, 32'h2);
    op_done <= 1'h1;
    @(posedge aclk);
    op_done <= 1'h0;
    @(posedge aclk);
    chk(reload_base, 1'h1);
    chk(irq_request, 1'h1);
    chk(channel_active, 1'h1);
    rc(ADDR_MEM_COUNT, 32'h2);
    rc(ADDR_CONTROL, 32'h1);
    wr(ADDR_ERROR, 32'h0);
    @(posedge aclk);
    chk(irq_request, 1'h0);
    wr(ADDR_CONTROL, 32'h2);
    fault(EC_TIMING, 32'h16);
    $display("continue done");
    summarize;
  end
endmodule // tb_dma_channel_termination_errors
